// ==== logic/sow_top.sv ====
// holds the option registers, part number and watchdog
// assumes rst is any reset and por_rst the power-on reset only
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module sow_top #(
  parameter int          LPO_DIV     = sow_pkg::LPO_DIV,
  parameter int          WIN_BUS_1   = sow_pkg::WIN_BUS_1,
  parameter int          WIN_BUS_2   = sow_pkg::WIN_BUS_2,
  parameter int          WIN_BUS_3   = sow_pkg::WIN_BUS_3,
  parameter int          LOG_BUS_1   = sow_pkg::LOG_BUS_1,
  parameter int          LOG_BUS_2   = sow_pkg::LOG_BUS_2,
  parameter int          LOG_BUS_3   = sow_pkg::LOG_BUS_3,
  parameter logic [11:0] PART_NUMBER = 12'h0a5
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        por_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        halt_executed,
  output logic             halt_allowed,
  output logic             system_reset_req,
  output logic             timer_clock_pin_enable,
  output logic             debug_pin_enable,
  output logic             reset_pin_enable,
  output logic             reset_pin_pullup,
  output logic             irq
);
  // PART_NUMBER value is arbitrary
  // pre_q is 17 bits and cnt_q 18 bits: refuse what they cannot hold
  initial begin
    if (LPO_DIV < 2 || LPO_DIV > 131072) begin
      $error("sow_top: LPO_DIV must lie in 2..131072");
    end
    if (LOG_BUS_1 < 2 || LOG_BUS_3 > 18) begin
      $error("sow_top: LOG_BUS values must lie in 2..18");
    end
    if (LOG_BUS_1 >= LOG_BUS_2 || LOG_BUS_2 >= LOG_BUS_3) begin
      $error("sow_top: LOG_BUS values must rise strictly");
    end
    if (WIN_BUS_1 >= (1 << LOG_BUS_1)) begin
      $error("sow_top: WIN_BUS_1 must lie inside its period");
    end
    if (WIN_BUS_2 >= (1 << LOG_BUS_2)) begin
      $error("sow_top: WIN_BUS_2 must lie inside its period");
    end
    if (WIN_BUS_3 >= (1 << LOG_BUS_3)) begin
      $error("sow_top: WIN_BUS_3 must lie inside its period");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state per access, answer on the second edge
  logic        ack_q;
  logic [31:0] rdata_q;
  wire         req     = avs_read | avs_write;
  wire         take    = req & ~ack_q;
  wire         wr_take = avs_write & take & avs_byteenable[0];
  wire [7:0]   wbyte   = avs_writedata[7:0];
  wire [4:0]   a       = avs_address;

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // option registers
  logic [1:0] timeout_q;
  logic       halt_en_q, external_timer_clock_q, dbg_q, rstp_q;
  logic       opt1_lock_q, clks_q, win_q, opt2_lock_q;
  logic [2:0] irq_st_q, irq_mk_q;
  logic       wdog_flag_q, ilop_flag_q;

  wire wr_opt1  = wr_take & (a == sow_pkg::ADDR_OPT1);
  wire wr_opt2  = wr_take & (a == sow_pkg::ADDR_OPT2);
  wire wr_rstat = wr_take & (a == sow_pkg::ADDR_RSTAT);
  wire wr_ist   = wr_take & (a == sow_pkg::ADDR_IRQ_ST);
  wire wr_imk   = wr_take & (a == sow_pkg::ADDR_IRQ_MK);
  wire w1_ok    = wr_opt1 & ~opt1_lock_q;
  wire w2_ok    = wr_opt2 & ~opt2_lock_q;

  // option one write-once fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timeout_q <= sow_pkg::RST_TIMEOUT;
      halt_en_q <= sow_pkg::RST_HALT;
      dbg_q     <= sow_pkg::RST_DBG;
    end else if (w1_ok) begin
      timeout_q <= wbyte[sow_pkg::OPT1_TO_HI:sow_pkg::OPT1_TO_LO];
      halt_en_q <= wbyte[sow_pkg::OPT1_HALT];
      dbg_q     <= wbyte[sow_pkg::OPT1_DBG];
    end
  end

  // the lock closes on the first write, whatever data it carries,
  // so a stray later write cannot reopen the watchdog settings
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opt1_lock_q <= 1'b0;
    end else if (w1_ok) begin
      opt1_lock_q <= 1'b1;
    end
  end

  // timer clock pin enable ignores the lock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      external_timer_clock_q <= sow_pkg::RST_EXTERNAL_TIMER_CLOCK;
    end else if (wr_opt1) begin
      external_timer_clock_q <= wbyte[sow_pkg::OPT1_EXTERNAL_TIMER_CLOCK];
    end
  end

  // option two locks on its own first write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clks_q      <= 1'b0;
      win_q       <= 1'b0;
      opt2_lock_q <= 1'b0;
    end else if (w2_ok) begin
      clks_q      <= wbyte[sow_pkg::OPT2_CLKS];
      win_q       <= wbyte[sow_pkg::OPT2_WIN];
      opt2_lock_q <= 1'b1;
    end
  end

  // reset-pin enable survives every reset except power-on
  always_ff @(posedge clock or posedge por_rst) begin
    if (por_rst) begin
      rstp_q <= sow_pkg::RST_RSTP;
    end else if (w1_ok) begin
      rstp_q <= wbyte[sow_pkg::OPT1_RSTP];
    end
  end

  assign halt_allowed           = halt_en_q;
  assign timer_clock_pin_enable = external_timer_clock_q;
  assign debug_pin_enable       = dbg_q;
  assign reset_pin_enable       = rstp_q & ~external_timer_clock_q;
  assign reset_pin_pullup       = rstp_q & ~external_timer_clock_q;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: slow tick prescaler and main counter
  function automatic int unsigned sel3(input logic [1:0] c, input int v1,
                                      input int v2, input int v3);
    sel3 = (c == 2'h1) ? v1 : (c == 2'h2) ? v2 : v3;
  endfunction

  logic [16:0] pre_q;
  logic [17:0] cnt_q;
  sow_pkg::sow_key_t key_q;
  logic        rst_req_q;

  wire wd_on    = (timeout_q != 2'h0);
  wire pre_wrap = (pre_q == 17'(LPO_DIV - 1));
  wire tick     = clks_q ? 1'b1 : pre_wrap;
  wire [4:0] log_sel = clks_q
    ? 5'(sel3(timeout_q, LOG_BUS_1, LOG_BUS_2, LOG_BUS_3))
    : 5'(sel3(timeout_q, sow_pkg::LOG_LPO_1, sow_pkg::LOG_LPO_2,
              sow_pkg::LOG_LPO_3));
  wire [18:0] period   = 19'h1 << log_sel;
  // window opens after three quarters of the period on the slow tick, at WIN_BUS_1, 2 or 3 on the bus clock
  wire [18:0] win_open = clks_q
    ? 19'(sel3(timeout_q, WIN_BUS_1, WIN_BUS_2, WIN_BUS_3))
    : 19'(period - (period >> 2));
  wire in_window = ({1'b0, cnt_q} >= win_open);
  wire overflow  = wd_on & tick & ({1'b0, cnt_q} == period - 19'h1);
  wire early_wr  = wd_on & win_q & wr_rstat & ~in_window;
  wire key_done  = wr_rstat & (key_q == sow_pkg::KEY_ARMED) &
                   (wbyte == sow_pkg::KEY_SECOND);
  wire refresh   = key_done & ~early_wr;
  wire ilop      = halt_executed & ~halt_en_q;
  wire cause_any = overflow | early_wr | ilop;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_q <= 17'h0;
    end else if (~wd_on | pre_wrap | refresh) begin
      pre_q <= 17'h0;
    end else begin
      pre_q <= pre_q + 17'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 18'h0;
    end else if (~wd_on | refresh | overflow) begin
      cnt_q <= 18'h0;
    end else if (tick) begin
      cnt_q <= cnt_q + 18'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_q <= sow_pkg::KEY_IDLE;
    end else if (wr_rstat) begin
      case (key_q)
        sow_pkg::KEY_IDLE: begin
          key_q <= (wbyte == sow_pkg::KEY_FIRST) ? sow_pkg::KEY_ARMED
                                                 : sow_pkg::KEY_IDLE;
        end
        sow_pkg::KEY_ARMED: begin
          // a repeated first key keeps the sequence armed
          if (wbyte == sow_pkg::KEY_FIRST) begin
            key_q <= sow_pkg::KEY_ARMED;
          end else begin
            key_q <= sow_pkg::KEY_IDLE;
          end
        end
        default: begin
          key_q <= sow_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // request pulse; the reset controller drives rst in answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= cause_any;
    end
  end
  assign system_reset_req = rst_req_q;

  // cause flags live on por_rst so they survive the reset they cause
  // each new cause replaces the old one: only the latest reset counts
  always_ff @(posedge clock or posedge por_rst) begin
    if (por_rst) begin
      wdog_flag_q <= 1'b0;
    end else if (cause_any) begin
      wdog_flag_q <= overflow | early_wr;
    end
  end

  always_ff @(posedge clock or posedge por_rst) begin
    if (por_rst) begin
      ilop_flag_q <= 1'b0;
    end else if (cause_any) begin
      ilop_flag_q <= ilop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over write-one-to-clear
  wire [2:0] ev_set = {early_wr, ilop, overflow};
  wire [2:0] ev_clr = {3{wr_ist}} & wbyte[2:0];
  logic [2:0] irq_st_d;

  // one sticky bit per event; a set in the clearing cycle is kept
  generate
    for (genvar i = 0; i < 3; i++) begin : g_ist
      assign irq_st_d[i] = ev_set[i] | (irq_st_q[i] & ~ev_clr[i]);
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_st_q <= 3'h0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_mk_q <= 3'h0;
    end else if (wr_imk) begin
      irq_mk_q <= wbyte[2:0];
    end
  end
  assign irq = |(irq_st_q & irq_mk_q);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  // reserved part number bits read zero, a fixed pick of "indeterminate"
  wire [7:0] opt1_rd  = {timeout_q, halt_en_q, external_timer_clock_q, 2'b00, dbg_q, rstp_q};
  wire [7:0] opt2_rd  = {clks_q, win_q, 6'h00};
  wire [7:0] pnh_rd   = {4'h0, PART_NUMBER[11:8]};
  wire [7:0] rstat_rd = {2'b00, wdog_flag_q, ilop_flag_q, 4'h0};
  wire [7:0] ist_rd   = {5'h00, irq_st_q};
  wire [7:0] imk_rd   = {5'h00, irq_mk_q};
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    case (a)
      sow_pkg::ADDR_OPT1:   rmux = opt1_rd;
      sow_pkg::ADDR_OPT2:   rmux = opt2_rd;
      sow_pkg::ADDR_PNH:    rmux = pnh_rd;
      sow_pkg::ADDR_PNL:    rmux = PART_NUMBER[7:0];
      sow_pkg::ADDR_RSTAT:  rmux = rstat_rd;
      sow_pkg::ADDR_IRQ_ST: rmux = ist_rd;
      sow_pkg::ADDR_IRQ_MK: rmux = imk_rd;
      default:              rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // read data are caught when the request is taken and then held
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (take & avs_read) begin
      rdata_q <= {24'h0, rmux};
    end
  end
endmodule

// ==== common/sow_pkg.sv ====
// package: offsets, field positions, reset values and timing counts
// assumes a 100 MHz bus clock and a registered avalon-mm slave
package sow_pkg;
  // register byte addresses
  localparam logic [4:0] ADDR_OPT1   = 5'h00;
  localparam logic [4:0] ADDR_OPT2   = 5'h04;
  localparam logic [4:0] ADDR_PNH    = 5'h08;
  localparam logic [4:0] ADDR_PNL    = 5'h0c;
  localparam logic [4:0] ADDR_RSTAT  = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ST = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MK = 5'h18;
  localparam logic [4:0] ADDR_EVENT  = 5'h1c;
  // option one fields
  localparam int OPT1_TO_HI  = 7;
  localparam int OPT1_TO_LO  = 6;
  localparam int OPT1_HALT   = 5;
  localparam int OPT1_EXTERNAL_TIMER_CLOCK   = 4;
  localparam int OPT1_DBG    = 1;
  localparam int OPT1_RSTP   = 0;
  localparam logic [7:0] OPT1_WMASK = 8'hf3;
  // option two fields
  localparam int OPT2_CLKS   = 7;
  localparam int OPT2_WIN    = 6;
  // reset-status fields
  localparam int RSTAT_WDOG  = 5;
  localparam int RSTAT_ILOP  = 4;
  // event / interrupt bits
  localparam int EV_WDOG     = 0;
  localparam int EV_ILOP     = 1;
  localparam int EV_WIN      = 2;
  // reset values
  localparam logic [1:0] RST_TIMEOUT = 2'h0;
  localparam logic       RST_HALT    = 1'b0;
  localparam logic       RST_EXTERNAL_TIMER_CLOCK    = 1'b0;
  localparam logic       RST_DBG     = 1'b1;
  localparam logic       RST_RSTP    = 1'b0;
  // refresh key bytes
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'haa;
  // timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int LPO_HZ       = 1_000;
  localparam int LPO_DIV      = CLK_HZ / LPO_HZ;
  localparam int LOG_LPO_1    = 5;
  localparam int LOG_LPO_2    = 8;
  localparam int LOG_LPO_3    = 10;
  localparam int LOG_BUS_1    = 13;
  localparam int LOG_BUS_2    = 16;
  localparam int LOG_BUS_3    = 18;
  localparam int WIN_BUS_1    = 6144;
  localparam int WIN_BUS_2    = 49152;
  localparam int WIN_BUS_3    = 196608;
  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED} sow_key_t;
endpackage

// ==== testbench/sow_chk.sv ====
// checker: port relations of the option and watchdog block
// assumes one clock domain and rst as its only reset
`timescale 1ns/1ps
module sow_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        halt_executed,
  input wire logic        halt_allowed,
  input wire logic        system_reset_req,
  input wire logic        debug_pin_enable,
  input wire logic        reset_pin_enable,
  input wire logic        reset_pin_pullup
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait state");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("more than one wait state");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  opt_hold_a: assert property (!avs_write
    |=> $stable({halt_allowed, debug_pin_enable}))
    else $error("option output moved without a write");
  halt_trap_a: assert property (halt_executed && !halt_allowed
    |-> ##[1:2] system_reset_req) else $error("illegal halt not trapped");
  req_pulse_a: assert property (system_reset_req |=> !system_reset_req)
    else $error("reset request longer than one cycle");
  dbg_back_a: assert property ($fell(rst) |-> debug_pin_enable)
    else $error("debug pin not enabled after reset");
  pullup_on_a: assert property (reset_pin_enable |-> reset_pin_pullup)
    else $error("reset pin without pullup");
  cover property (system_reset_req);
  cover property (halt_executed && halt_allowed);
  cover property ($rose(avs_write));
endmodule
bind sow_top sow_chk u_chk (.clock(clock), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .avs_readdata(avs_readdata), .halt_executed(halt_executed),
  .halt_allowed(halt_allowed), .system_reset_req(system_reset_req),
  .debug_pin_enable(debug_pin_enable), .reset_pin_enable(reset_pin_enable),
  .reset_pin_pullup(reset_pin_pullup));

// ==== testbench/sow_top_tb.sv ====
// testbench: option registers, watchdog, halt trap and interrupt
// assumes the shortened watchdog counts set at the instance
`timescale 1ns/1ps
module sow_top_tb;
  logic        clock = 0, rst = 1, por_rst = 1, avs_read = 0, avs_write = 0;
  logic        halt_executed = 0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, halt_allowed, system_reset_req, tcpe;
  wire         debug_pin_enable, reset_pin_enable, reset_pin_pullup, irq;
  int          fails = 0, cmp_count = 0, n, req_seen = 0;
  logic [7:0]  r;
  always #5 clock = ~clock;
  // reset request pulses are one cycle; count them so none is missed
  always @(posedge clock) if (system_reset_req === 1'b1) req_seen++;
  // part number value is arbitrary
  sow_top #(.LPO_DIV(4), .LOG_BUS_1(6), .WIN_BUS_1(48),
    .PART_NUMBER(12'h3c6)) u_dut (.clock(clock), .rst(rst),
    .por_rst(por_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_executed(halt_executed),
    .halt_allowed(halt_allowed), .system_reset_req(system_reset_req),
    .timer_clock_pin_enable(tcpe), .debug_pin_enable(debug_pin_enable),
    .reset_pin_enable(reset_pin_enable),
    .reset_pin_pullup(reset_pin_pullup), .irq(irq));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [7:0] g, logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // the request is held until waitrequest is sampled low
  task automatic acc();
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1;
    acc();
    avs_write <= 0;
    @(posedge clock);
  endtask
  task automatic rd(logic [4:0] a);
    avs_address <= a;
    avs_read <= 1;
    acc();
    r = avs_readdata[7:0];
    avs_read <= 0;
    @(posedge clock);
  endtask
  task automatic wait_rr(int lim);
    n = 0;
    while (system_reset_req !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic rs(logic p);
    rst <= 1;
    por_rst <= p;
    repeat (4) @(posedge clock);
    rst <= 0;
    por_rst <= 0;
    @(posedge clock);
  endtask
  task automatic halt();
    halt_executed <= 1;
    @(posedge clock);
    halt_executed <= 0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(sow_pkg::ADDR_OPT1);
    chk("opt1", r, 8'h02);
    rd(sow_pkg::ADDR_OPT2);
    chk("opt2", r, 8'h00);
    rd(sow_pkg::ADDR_PNH);
    chk("pnh", {4'h0, r[3:0]}, 8'h03);
    wr(sow_pkg::ADDR_PNL, 8'h00);
    rd(sow_pkg::ADDR_PNL);
    chk("pnl", r, 8'hc6);
    rd(sow_pkg::ADDR_EVENT);
    chk("unmapped", r, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_slow();
    wr(sow_pkg::ADDR_OPT1, 8'h63);
    wr(sow_pkg::ADDR_OPT1, 8'h12);
    rd(sow_pkg::ADDR_OPT1);
    chk("locked", r, 8'h73);
    chk("halt ok", halt_allowed, 8'h01);
    chk("external_timer_clock", tcpe, 8'h01);
    chk("rst pin gated", reset_pin_enable, 8'h00);
    wait_rr(90);
    chk("early", 8'(n == 90), 8'h01);
    wr(sow_pkg::ADDR_RSTAT, 8'h55);
    wr(sow_pkg::ADDR_RSTAT, 8'haa);
    // tick phase of the slow clock gives a few cycles of slack
    wait_rr(200);
    chk("slow period", 8'(n >= 118 && n <= 132), 8'h01);
    rs(0);
    rd(sow_pkg::ADDR_RSTAT);
    chk("cause", r & 8'h20, 8'h20);
    rd(sow_pkg::ADDR_OPT1);
    chk("after rst", r, 8'h03);
    chk("pullup", reset_pin_pullup, 8'h01);
    chk("rst pin", reset_pin_enable, 8'h01);
    $display("test slow done");
  endtask
  task automatic t_win();
    int m;
    rs(1);
    wr(sow_pkg::ADDR_OPT2, 8'hc0);
    wr(sow_pkg::ADDR_OPT2, 8'h00);
    rd(sow_pkg::ADDR_OPT2);
    chk("opt2 lock", r, 8'hc0);
    wr(sow_pkg::ADDR_OPT1, 8'h42);
    m = req_seen;
    wr(sow_pkg::ADDR_RSTAT, 8'h55);
    wait_rr(6);
    chk("early key", 8'(req_seen - m), 8'h01);
    rs(0);
    wr(sow_pkg::ADDR_OPT2, 8'hc0);
    wr(sow_pkg::ADDR_OPT1, 8'h42);
    wait_rr(46);
    chk("closed", 8'(n == 46), 8'h01);
    wr(sow_pkg::ADDR_RSTAT, 8'h55);
    wr(sow_pkg::ADDR_RSTAT, 8'haa);
    wait_rr(80);
    chk("bus period", 8'(n >= 58 && n <= 66), 8'h01);
    $display("test window done");
  endtask
  task automatic t_halt();
    rs(1);
    wr(sow_pkg::ADDR_OPT1, 8'h02);
    wr(sow_pkg::ADDR_IRQ_MK, 8'h02);
    halt();
    wait_rr(4);
    chk("trap", 8'(n < 4), 8'h01);
    repeat (2) @(posedge clock);
    chk("irq on", irq, 8'h01);
    rd(sow_pkg::ADDR_IRQ_ST);
    chk("status", r & 8'h02, 8'h02);
    wr(sow_pkg::ADDR_IRQ_ST, 8'h02);
    chk("irq off", irq, 8'h00);
    wr(sow_pkg::ADDR_IRQ_MK, 8'h00);
    halt();
    repeat (3) @(posedge clock);
    chk("masked", irq, 8'h00);
    wait_rr(300);
    chk("disabled", 8'(n == 300), 8'h01);
    rs(0);
    wr(sow_pkg::ADDR_OPT1, 8'h22);
    halt();
    wait_rr(10);
    chk("halt allowed", 8'(n == 10), 8'h01);
    $display("test halt done");
  endtask
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    rs(1);
    t_regs();
    t_slow();
    t_win();
    t_halt();
    tally_and_finish();
  end
endmodule
